// >>> pin_route_defines.svh
// Constants for the peripheral input pin router: codes, indices, reset values, keys
`ifndef PIN_ROUTE_DEFINES_SVH
`define PIN_ROUTE_DEFINES_SVH

`define PIN_CODE_W 6
`define IDX_W 5
`define NUM_IN 23
`define NUM_OUT 8
`define SEL_COUNT 31
`define OUT_BASE 5'h17
`define PIN_COUNT 48
`define PORT_SIZE 6'h08
`define LAST_PORT5_CODE 6'h22
`define PORT6_BASE 6'h28
`define MAX_CODE 6'h2f
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'haa
`define LOCKED_BIT 0
`define OUT_CODE_W 5
`define OUT_CODE_COUNT 28
`define OUT_LATCH_CODE 5'h00
`define OUT_CODE_SCK1 5'h15
`define OUT_CODE_SDA1 5'h16
`define OUT_CODE_CK1 5'h0f
`define OUT_CODE_DT1 5'h10
`define OUT_SEL_RESET 6'h00
`define I2C_PIN_MASK 48'h0000_0018_0600
// Input selection indices used by name
`define IDX_SSP1_CLK 13
`define IDX_SSP1_DAT 14
`define IDX_SSP2_CLK 16
`define IDX_SSP2_DAT 17
`define IDX_RX1_DT 19
`define IDX_CK1 20
// Power-on default pin codes, one per peripheral input in index order
`define DEF_EXT_IRQ 6'h08
`define DEF_T0CKI 6'h04
`define DEF_T1CKI 6'h10
`define DEF_T1G 6'h0d
`define DEF_T2IN 6'h13
`define DEF_CCP1 6'h12
`define DEF_CCP2 6'h11
`define DEF_CWG1IN 6'h08
`define DEF_CLCIN0 6'h00
`define DEF_CLCIN1 6'h01
`define DEF_CLCIN2 6'h0e
`define DEF_CLCIN3 6'h0f
`define DEF_ADACT 6'h0c
`define DEF_SSP1_CLK 6'h13
`define DEF_SSP1_DAT 6'h14
`define DEF_SSP1_SS 6'h05
`define DEF_SSP2_CLK 6'h09
`define DEF_SSP2_DAT 6'h0a
`define DEF_SSP2_SS 6'h08
`define DEF_RX1_DT 6'h17
`define DEF_CK1 6'h16
`define DEF_RX2_DT 6'h0f
`define DEF_CK2 6'h0e

`endif

// >>> pin_route_pkg.sv
// Types shared by the pin router and its selection store
package pin_route_pkg;

    typedef enum logic [1:0] {
        LOCK_IDLE,
        LOCK_GOT_KEY1,
        LOCK_ARMED
    } lock_seq_type;

    typedef enum logic [1:0] {
        THR_TTL,
        THR_SCHMITT,
        THR_TWO_WIRE
    } threshold_type;

    typedef struct packed {
        logic [30:0][5:0] sel;
        logic [5:0] rd;
    } sel_store_state_type;

    typedef struct packed {
        lock_seq_type seq;
        logic locked;
        logic cleared_once;
        logic perm;
        logic [22:0] periph_in;
        logic [7:0] pin_out;
        logic [3:0] conflict;
        logic [7:0] thr;
    } router_state_type;

endpackage : pin_route_pkg

// >>> sel_store.sv
// Selection register store: all input and output pin selections
`timescale 1ns/1ns
`default_nettype none
`include "pin_route_defines.svh"

module sel_store (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [4:0] wr_index,
    input wire logic [5:0] wr_data,
    input wire logic [4:0] rd_index,
    output logic [5:0] rd_data,
    output logic [30:0][5:0] sel_all
);

    pin_route_pkg::sel_store_state_type st_q;
    pin_route_pkg::sel_store_state_type st_d;

    function automatic logic [5:0] default_sel(input logic [4:0] i);
        case (i)
            5'h00: default_sel = `DEF_EXT_IRQ;
            5'h01: default_sel = `DEF_T0CKI;
            5'h02: default_sel = `DEF_T1CKI;
            5'h03: default_sel = `DEF_T1G;
            5'h04: default_sel = `DEF_T2IN;
            5'h05: default_sel = `DEF_CCP1;
            5'h06: default_sel = `DEF_CCP2;
            5'h07: default_sel = `DEF_CWG1IN;
            5'h08: default_sel = `DEF_CLCIN0;
            5'h09: default_sel = `DEF_CLCIN1;
            5'h0a: default_sel = `DEF_CLCIN2;
            5'h0b: default_sel = `DEF_CLCIN3;
            5'h0c: default_sel = `DEF_ADACT;
            5'h0d: default_sel = `DEF_SSP1_CLK;
            5'h0e: default_sel = `DEF_SSP1_DAT;
            5'h0f: default_sel = `DEF_SSP1_SS;
            5'h10: default_sel = `DEF_SSP2_CLK;
            5'h11: default_sel = `DEF_SSP2_DAT;
            5'h12: default_sel = `DEF_SSP2_SS;
            5'h13: default_sel = `DEF_RX1_DT;
            5'h14: default_sel = `DEF_CK1;
            5'h15: default_sel = `DEF_RX2_DT;
            5'h16: default_sel = `DEF_CK2;
            default: default_sel = `OUT_SEL_RESET;
        endcase
    endfunction : default_sel

    always_comb begin
        st_d = st_q;
        if (wr_en && (wr_index < 5'(`SEL_COUNT))) begin
            st_d.sel[wr_index] = wr_data;
        end
        // Unmapped read index reads zero
        st_d.rd = (rd_index < 5'(`SEL_COUNT)) ? st_q.sel[rd_index] : 6'h00;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < `SEL_COUNT; i++) begin
                st_q.sel[i] <= default_sel(5'(i));
            end
            st_q.rd <= 6'h00;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rd;
    assign sel_all = st_q.sel;

endmodule : sel_store

`default_nettype wire

// >>> pin_route_select.sv
// Peripheral input pin router with guarded global selection lock
//
// Summary of operation
// - Input pin codes give each port a group of eight, the fifth port has three pins and the sixth starts at 0x28.
// - The same-pin need applies to the serial transceiver in synchronous mode and the serial port in two-wire mode.
// - Two-wire clock and data get two-wire thresholds only on dedicated pins, else the selected TTL or Schmitt buffer.
// - While the lock bit is set no input or output selection can change.
// - The lock bit changes only after the guarded write sequence, which software performs for every set or clear.
// - The guard is 0x55 then 0xAA to the lock register, then the write that sets or clears the lock bit.
// - With the one-shot configuration set, the lock may be cleared and set once per reset, then stays set.
// - Power-on reset restores default selections and removes the permanent lock.
// - Sleep entry or exit leaves every selection unchanged.
`timescale 1ns/1ns
`default_nettype none
`include "pin_route_defines.svh"

module pin_route_select (
    input wire logic core_clk,
    input wire logic rst,
    // Selection register write and readback; index 0-22 inputs, 23-30 output pins
    input wire logic sel_wr_en,
    input wire logic [4:0] sel_wr_index,
    input wire logic [5:0] sel_wr_data,
    input wire logic [4:0] sel_rd_index,
    output logic [5:0] sel_rd_data,
    // Lock register access
    input wire logic lock_wr_en,
    input wire logic [7:0] lock_wr_data,
    input wire logic one_shot_lock_cfg,
    output logic route_locked_bit,
    output logic route_lock_permanent,
    // Pin side
    input wire logic [47:0] pin_levels,
    input wire logic [47:0] input_threshold_select,
    input wire logic [7:0] port_latch,
    output logic [7:0] pin_out,
    // Peripheral side
    input wire logic [27:0] periph_out,
    output logic [22:0] periph_in,
    input wire logic sync_serial_two_wire_mode,
    input wire logic serial_transceiver_sync_mode,
    output logic [3:0] route_conflict,
    output logic [7:0] two_wire_threshold
);

    pin_route_pkg::router_state_type st_q;
    pin_route_pkg::router_state_type st_d;
    logic [30:0][5:0] sel_all;
    logic sel_wr_ok;

    ////////////////////////////////////////////////////////////////////////////

    // Codes in the gap after the fifth port's third pin, or past the sixth port, select nothing
    function automatic logic code_valid(input logic [5:0] code);
        code_valid = (code <= `LAST_PORT5_CODE) ||
                     ((code >= `PORT6_BASE) && (code <= `MAX_CODE));
    endfunction : code_valid

    function automatic logic pin_level(input logic [5:0] code, input logic [47:0] lv);
        pin_level = code_valid(code) ? lv[code] : 1'b0;
    endfunction : pin_level

    // Only the first port's pins carry routed outputs, so a peer pin elsewhere never matches
    function automatic logic same_pin(input logic [5:0] in_code,
                                      input logic [30:0][5:0] sels,
                                      input logic [4:0] out_code);
        logic [4:0] idx;
        idx = `OUT_BASE + in_code[4:0];
        same_pin = (in_code < `PORT_SIZE) && (sels[idx][4:0] == out_code);
    endfunction : same_pin

    function automatic logic [1:0] threshold_of(input logic [5:0] code,
                                               input logic two_wire,
                                               input logic [47:0] thr_sel);
        logic dedicated;
        logic [47:0] mask;
        // A bit-select cannot be taken on a literal, so the mask goes through a variable
        mask = `I2C_PIN_MASK;
        dedicated = code_valid(code) && mask[code];
        if (two_wire && dedicated) begin
            threshold_of = pin_route_pkg::THR_TWO_WIRE;
        end else if (code_valid(code) && thr_sel[code]) begin
            threshold_of = pin_route_pkg::THR_SCHMITT;
        end else begin
            threshold_of = pin_route_pkg::THR_TTL;
        end
    endfunction : threshold_of

    ////////////////////////////////////////////////////////////////////////////

    // Gate is taken from the registered lock, so the write that sets it is the last let through
    assign sel_wr_ok = sel_wr_en && !st_q.locked;

    sel_store sel_store_inst (
        .core_clk(core_clk),
        .rst(rst),
        .wr_en(sel_wr_ok),
        .wr_index(sel_wr_index),
        .wr_data(sel_wr_data),
        .rd_index(sel_rd_index),
        .rd_data(sel_rd_data),
        .sel_all(sel_all)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic want_lock;
        logic [4:0] oc;
        want_lock = lock_wr_data[`LOCKED_BIT];
        oc = 5'h00;
        st_d = st_q;

        // Guard sequence; a selection write in between also breaks it
        if (sel_wr_en) begin
            st_d.seq = pin_route_pkg::LOCK_IDLE;
        end
        if (lock_wr_en) begin
            case (st_q.seq)
                pin_route_pkg::LOCK_IDLE: begin
                    st_d.seq = (lock_wr_data == `UNLOCK_KEY1) ?
                               pin_route_pkg::LOCK_GOT_KEY1 : pin_route_pkg::LOCK_IDLE;
                end
                pin_route_pkg::LOCK_GOT_KEY1: begin
                    st_d.seq = (lock_wr_data == `UNLOCK_KEY2) ?
                               pin_route_pkg::LOCK_ARMED : pin_route_pkg::LOCK_IDLE;
                end
                pin_route_pkg::LOCK_ARMED: begin
                    st_d.seq = pin_route_pkg::LOCK_IDLE;
                    if (!st_q.perm) begin
                        st_d.locked = want_lock;
                        if (one_shot_lock_cfg && st_q.locked && !want_lock) begin
                            st_d.cleared_once = 1'b1;
                        end
                        if (one_shot_lock_cfg && want_lock && st_q.cleared_once) begin
                            st_d.perm = 1'b1;
                        end
                    end
                end
                default: begin
                    st_d.seq = pin_route_pkg::LOCK_IDLE;
                end
            endcase
        end

        // Routing needs no clock gating, so sleep transitions cannot disturb selections
        for (int i = 0; i < `NUM_IN; i++) begin
            st_d.periph_in[i] = pin_level(sel_all[i], pin_levels);
        end
        for (int p = 0; p < `NUM_OUT; p++) begin
            oc = sel_all[`SEL_COUNT - `NUM_OUT + p][4:0];
            if (oc == `OUT_LATCH_CODE || oc >= 5'(`OUT_CODE_COUNT)) begin
                st_d.pin_out[p] = port_latch[p];
            end else begin
                st_d.pin_out[p] = periph_out[oc];
            end
        end

        // Same-pin checks for bidirectional functions
        st_d.conflict[0] = sync_serial_two_wire_mode &&
            !same_pin(sel_all[`IDX_SSP1_CLK], sel_all, `OUT_CODE_SCK1);
        st_d.conflict[1] = sync_serial_two_wire_mode &&
            !same_pin(sel_all[`IDX_SSP1_DAT], sel_all, `OUT_CODE_SDA1);
        st_d.conflict[2] = serial_transceiver_sync_mode &&
            !same_pin(sel_all[`IDX_RX1_DT], sel_all, `OUT_CODE_DT1);
        st_d.conflict[3] = serial_transceiver_sync_mode &&
            !same_pin(sel_all[`IDX_CK1], sel_all, `OUT_CODE_CK1);

        st_d.thr[1:0] = threshold_of(sel_all[`IDX_SSP1_CLK], sync_serial_two_wire_mode,
                                     input_threshold_select);
        st_d.thr[3:2] = threshold_of(sel_all[`IDX_SSP1_DAT], sync_serial_two_wire_mode,
                                     input_threshold_select);
        st_d.thr[5:4] = threshold_of(sel_all[`IDX_SSP2_CLK], sync_serial_two_wire_mode,
                                     input_threshold_select);
        st_d.thr[7:6] = threshold_of(sel_all[`IDX_SSP2_DAT], sync_serial_two_wire_mode,
                                     input_threshold_select);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q.seq <= pin_route_pkg::LOCK_IDLE;
            st_q.locked <= 1'b0;
            st_q.cleared_once <= 1'b0;
            st_q.perm <= 1'b0;
            st_q.periph_in <= 23'h000000;
            st_q.pin_out <= 8'h00;
            st_q.conflict <= 4'h0;
            st_q.thr <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    assign route_locked_bit = st_q.locked;
    assign route_lock_permanent = st_q.perm;
    assign periph_in = st_q.periph_in;
    assign pin_out = st_q.pin_out;
    assign route_conflict = st_q.conflict;
    assign two_wire_threshold = st_q.thr;

endmodule : pin_route_select

`default_nettype wire

// >>> pin_route_monitor.sv
// Port-level assertion checker for the pin router, bound to its top module
`timescale 1ns/1ns
`default_nettype none

module pin_route_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [4:0] sel_rd_index,
    input wire logic [5:0] sel_rd_data,
    input wire logic lock_wr_en,
    input wire logic [7:0] lock_wr_data,
    input wire logic one_shot_lock_cfg,
    input wire logic route_locked_bit,
    input wire logic route_lock_permanent,
    input wire logic [22:0] periph_in,
    input wire logic sync_serial_two_wire_mode,
    input wire logic serial_transceiver_sync_mode,
    input wire logic [3:0] route_conflict,
    input wire logic [7:0] two_wire_threshold
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    a_lock_set_guard: assert property ($rose(route_locked_bit) |->
        $past(lock_wr_en) && $past(lock_wr_data[0])) else $error("lock set without write");
    a_lock_clr_guard: assert property ($fell(route_locked_bit) |->
        $past(lock_wr_en) && !$past(lock_wr_data[0])) else $error("lock cleared without write");
    a_perm_stays_locked: assert property (route_lock_permanent |-> route_locked_bit)
        else $error("permanent lock while unlocked");
    a_perm_needs_cfg: assert property ($rose(route_lock_permanent) |->
        $past(one_shot_lock_cfg) && route_locked_bit) else $error("permanent lock without cfg");
    a_reset_clears_all: assert property (disable iff (1'b0) rst |=>
        !route_locked_bit && !route_lock_permanent && periph_in == 23'h0 && sel_rd_data == 6'h00)
        else $error("reset left state behind");
    // Readback may only move when the index moves or a write slipped past the lock
    a_locked_readback: assert property ($past(route_locked_bit) && $stable(sel_rd_index) |=>
        $stable(sel_rd_data)) else $error("selection changed while locked");
    a_thr_needs_mode: assert property (!sync_serial_two_wire_mode |=>
        two_wire_threshold[1:0] != 2'h2 && two_wire_threshold[3:2] != 2'h2 &&
        two_wire_threshold[5:4] != 2'h2 && two_wire_threshold[7:6] != 2'h2)
        else $error("two-wire threshold outside two-wire mode");
    a_conf_uart_mode: assert property (!serial_transceiver_sync_mode |=>
        route_conflict[3:2] == 2'h0) else $error("transceiver flag outside sync mode");
    a_conf_ssp_mode: assert property (!sync_serial_two_wire_mode |=>
        route_conflict[1:0] == 2'h0) else $error("serial port flag outside two-wire mode");
endmodule : pin_route_monitor

bind pin_route_select pin_route_monitor pin_route_monitor_inst (.core_clk, .rst,
    .sel_rd_index, .sel_rd_data, .lock_wr_en, .lock_wr_data, .one_shot_lock_cfg,
    .route_locked_bit, .route_lock_permanent, .periph_in, .sync_serial_two_wire_mode,
    .serial_transceiver_sync_mode, .route_conflict, .two_wire_threshold);

`default_nettype wire

// >>> pin_env_model.sv
// Far-side model: package pin levels and on-chip peripheral outputs
`timescale 1ns/1ns
`default_nettype none

module pin_env_model (
    output logic [47:0] pin_levels,
    output logic [27:0] periph_out
);
    // Mixed start pattern so a route to a wrong pin cannot pass on a lucky zero
    initial pin_levels = 48'h5a5a_5a5a_5a5a;
    initial periph_out = 28'h0;
    task set_pins(input logic [47:0] v);
        pin_levels = v;
    endtask : set_pins
    task set_outs(input logic [27:0] v);
        periph_out = v;
    endtask : set_outs
endmodule : pin_env_model

`default_nettype wire

// >>> pin_route_select_tb.sv
// Self-checking testbench for the pin router
`timescale 1ns/1ns
`default_nettype none
`include "pin_route_defines.svh"

module pin_route_select_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic sel_wr_en = 1'b0, lock_wr_en = 1'b0, one_shot_lock_cfg = 1'b0;
    logic [4:0] sel_wr_index = 5'h00, sel_rd_index = 5'h00;
    logic [5:0] sel_wr_data = 6'h00, sel_rd_data;
    logic [7:0] lock_wr_data = 8'h00, port_latch = 8'ha5, pin_out, two_wire_threshold;
    logic [47:0] pin_levels, input_threshold_select = 48'h0;
    logic [27:0] periph_out;
    logic [22:0] periph_in;
    logic sync_serial_two_wire_mode = 1'b0, serial_transceiver_sync_mode = 1'b0;
    logic route_locked_bit, route_lock_permanent;
    logic [3:0] route_conflict;
    int error_cnt = 0, check_count = 0, i;
    logic [5:0] defs [23] = '{`DEF_EXT_IRQ, `DEF_T0CKI, `DEF_T1CKI, `DEF_T1G, `DEF_T2IN,
        `DEF_CCP1, `DEF_CCP2, `DEF_CWG1IN, `DEF_CLCIN0, `DEF_CLCIN1, `DEF_CLCIN2, `DEF_CLCIN3,
        `DEF_ADACT, `DEF_SSP1_CLK, `DEF_SSP1_DAT, `DEF_SSP1_SS, `DEF_SSP2_CLK, `DEF_SSP2_DAT,
        `DEF_SSP2_SS, `DEF_RX1_DT, `DEF_CK1, `DEF_RX2_DT, `DEF_CK2};
    logic [5:0] codes [4] = '{6'h00, 6'h0f, 6'h28, 6'h2f};

    always #25 core_clk = ~core_clk;

    pin_env_model pin_env_model_inst (.pin_levels(pin_levels), .periph_out(periph_out));
    pin_route_select pin_route_select_inst (.core_clk(core_clk), .rst(rst),
        .sel_wr_en(sel_wr_en), .sel_wr_index(sel_wr_index), .sel_wr_data(sel_wr_data),
        .sel_rd_index(sel_rd_index), .sel_rd_data(sel_rd_data), .lock_wr_en(lock_wr_en),
        .lock_wr_data(lock_wr_data), .one_shot_lock_cfg(one_shot_lock_cfg),
        .route_locked_bit(route_locked_bit), .route_lock_permanent(route_lock_permanent),
        .pin_levels(pin_levels), .input_threshold_select(input_threshold_select),
        .port_latch(port_latch), .pin_out(pin_out), .periph_out(periph_out),
        .periph_in(periph_in), .sync_serial_two_wire_mode(sync_serial_two_wire_mode),
        .serial_transceiver_sync_mode(serial_transceiver_sync_mode),
        .route_conflict(route_conflict), .two_wire_threshold(two_wire_threshold));
    ////////////////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask : tick
    task check(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task sel_wr(input logic [4:0] idx, input logic [5:0] d);
        sel_wr_en = 1'b1;
        sel_wr_index = idx;
        sel_wr_data = d;
        tick(1);
        sel_wr_en = 1'b0;
        // One idle edge so a following call never re-raises the strobe in the same step
        tick(1);
    endtask : sel_wr
    task sel_rd(input logic [4:0] idx, input logic [5:0] exp);
        sel_rd_index = idx;
        tick(1);
        check(sel_rd_data, exp);
    endtask : sel_rd
    task lock_wr(input logic [7:0] d);
        lock_wr_en = 1'b1;
        lock_wr_data = d;
        tick(1);
        lock_wr_en = 1'b0;
        // Idle edges between keys are allowed by the guard sequence
        tick(1);
    endtask : lock_wr
    // Keys one idle edge apart, as software does with interrupts held off
    task guard(input logic b);
        lock_wr(`UNLOCK_KEY1);
        lock_wr(`UNLOCK_KEY2);
        lock_wr({7'h00, b});
        tick(1);
    endtask : guard
    task final_report;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        error_cnt++;
        final_report;
    end

    initial begin
        tick(2);
        rst = 1'b0;
        tick(1);
        for (i = 0; i < 23; i++) sel_rd(i[4:0], defs[i]);
        sel_rd(5'd23, `OUT_SEL_RESET);
        for (i = 0; i < 4; i++) begin
            sel_wr(5'd1, codes[i]);
            pin_env_model_inst.set_pins(48'h1 << codes[i]);
            tick(2);
            check(periph_in[1], 1'b1);
            pin_env_model_inst.set_pins(~(48'h1 << codes[i]));
            tick(2);
            check(periph_in[1], 1'b0);
        end
        guard(1'b1);
        check(route_locked_bit, 1'b1);
        sel_wr(5'd1, 6'h04);
        sel_rd(5'd1, 6'h2f);
        lock_wr(8'h00);
        tick(1);
        check(route_locked_bit, 1'b1);
        lock_wr(8'h55);
        lock_wr(8'h12);
        lock_wr(8'haa);
        lock_wr(8'h00);
        tick(1);
        check(route_locked_bit, 1'b1);
        guard(1'b0);
        check(route_locked_bit, 1'b0);
        sel_wr(5'd20, 6'h02);
        sel_wr(5'd25, {1'b0, `OUT_CODE_CK1});
        pin_env_model_inst.set_outs(28'h000_8000);
        serial_transceiver_sync_mode = 1'b1;
        sync_serial_two_wire_mode = 1'b1;
        input_threshold_select = 48'h1;
        tick(2);
        check(route_conflict[3], 1'b0);
        check(pin_out[2], 1'b1);
        check(pin_out[0], 1'b1);
        check(two_wire_threshold[1:0], 2'h2);
        sel_wr(5'd13, 6'h00);
        sel_wr(5'd25, 6'h00);
        tick(2);
        check(two_wire_threshold[1:0], 2'h1);
        check(route_conflict[3], 1'b1);
        one_shot_lock_cfg = 1'b1;
        guard(1'b1);
        guard(1'b0);
        guard(1'b1);
        check(route_lock_permanent, 1'b1);
        guard(1'b0);
        check(route_locked_bit, 1'b1);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        check(route_lock_permanent, 1'b0);
        sel_rd(5'd13, `DEF_SSP1_CLK);
        final_report;
    end
endmodule : pin_route_select_tb

`default_nettype wire
